// [core/mpd_consts.svh]
// constants for the multifunction pin input decoder
// assumes inclusion by core files only; no logic here
`ifndef MPD_CONSTS_SVH
`define MPD_CONSTS_SVH
// register byte addresses (word aligned, avalon-mm)
`define MPD_CFG_OFS 4'h0
`define MPD_STAT_OFS 4'h4
`define MPD_CTRL_OFS 4'h8
// configuration field layout
`define MPD_DIR_BIT 7
// configuration reset value: no function attached
`define MPD_CFG_RST 8'h00
// input function codes
`define MPD_C_HIZ 8'h00
`define MPD_C_TWH_RST 8'h05
`define MPD_C_HOLDOVER 8'h10
`define MPD_C_FREERUN 8'h11
`define MPD_C_PHS_RST 8'h12
`define MPD_C_PHS_INC 8'h13
`define MPD_C_PHS_DEC 8'h14
`define MPD_C_OVR_BASE 8'h20
`define MPD_C_VTO_BASE 8'h30
`define MPD_C_OEN_BASE 8'h40
`define MPD_C_OEN_ALL 8'h46
`define MPD_C_SYNC 8'h47
// control strobe vector positions
`define MPD_S_TWH 0
`define MPD_S_HOLD 1
`define MPD_S_FREE 2
`define MPD_S_PRST 3
`define MPD_S_PINC 4
`define MPD_S_PDEC 5
`define MPD_S_SYNC 6
`define MPD_S_OVR 7
`define MPD_S_VTO 11
`define MPD_S_OEN 15
`define MPD_S_W 21
`endif

// [core/mpd_pkg.sv]
// types for the multifunction pin input decoder
// assumes mpd_consts.svh is on the include path
package mpd_pkg;
  `include "mpd_consts.svh"
  // strobe vector, one bit per mirrored control bit
  typedef logic [`MPD_S_W-1:0] mpd_strobe_type;
  // bus answer states
  typedef enum logic [2:0] {
    MPD_IDLE = 3'b001,
    MPD_ACK = 3'b010,
    MPD_DONE = 3'b100
  } mpd_bus_type;
endpackage : mpd_pkg

// [core/mpd_decode.sv]
// combinational decode of configuration code to strobe vector
// assumes the pin level is already synchronous to the system clock
`timescale 1ns/1ps
`include "mpd_consts.svh"
module mpd_decode (
  // code and pin
  input wire logic [7:0] cfg_code,
  input wire logic pin_level,
  // decoded strobes
  output mpd_pkg::mpd_strobe_type strobe
);
  import mpd_pkg::*;

  // decode code and route pin level
  always_comb begin
    strobe = '0;
    if (!cfg_code[`MPD_DIR_BIT]) begin
      case (cfg_code)
        `MPD_C_HIZ: strobe = '0;
        `MPD_C_TWH_RST: strobe[`MPD_S_TWH] = pin_level;
        `MPD_C_HOLDOVER: strobe[`MPD_S_HOLD] = pin_level;
        `MPD_C_FREERUN: strobe[`MPD_S_FREE] = pin_level;
        `MPD_C_PHS_RST: strobe[`MPD_S_PRST] = pin_level;
        `MPD_C_PHS_INC: strobe[`MPD_S_PINC] = pin_level;
        `MPD_C_PHS_DEC: strobe[`MPD_S_PDEC] = pin_level;
        `MPD_C_OEN_ALL: strobe[`MPD_S_OEN +: 6] = {6{pin_level}};
        `MPD_C_SYNC: strobe[`MPD_S_SYNC] = pin_level;
        default: begin
          if (cfg_code[7:2] == 6'(`MPD_C_OVR_BASE >> 2))
            strobe[`MPD_S_OVR + 32'(cfg_code[1:0])] = pin_level;
          else if (cfg_code[7:2] == 6'(`MPD_C_VTO_BASE >> 2))
            strobe[`MPD_S_VTO + 32'(cfg_code[1:0])] = pin_level;
          else if (cfg_code[7:3] == 5'(`MPD_C_OEN_BASE >> 3) && cfg_code[2:0] < 3'h6)
            strobe[`MPD_S_OEN + 32'(cfg_code[2:0])] = pin_level;
          else
            strobe = '0;
        end
      endcase
    end
  end
endmodule : mpd_decode

// [core/mpd_top.sv]
// multifunction pin input decoder with avalon-mm configuration
// assumes pin and bus are synchronous to clock
// assumes the bus master holds each request until waitrequest is low
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "mpd_consts.svh"
module mpd_top (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // multifunction pin
  input wire logic mf_pin,
  // mirrored control strobes
  output logic twh_reset_ff,
  output logic user_holdover_ff,
  output logic user_freerun_ff,
  output logic phase_reset_ff,
  output logic phase_inc_ff,
  output logic phase_dec_ff,
  output logic dist_sync_ff,
  output logic [3:0] mon_override_ff,
  output logic [3:0] vto_force_ff,
  output logic [5:0] out_enable_ff
);
  import mpd_pkg::*;

  logic [7:0] cfg_ff; // configuration byte
  mpd_strobe_type sw_ctrl_ff; // software-written control bits, only 21 kept
  logic wr_ack; // held write accepted at this edge
  wire logic [`MPD_S_W-1:0] lane_mask; // control bits reached by enabled lanes
  mpd_strobe_type pin_strobe; // decoded pin contribution
  mpd_strobe_type nxt_strobe; // combined strobe value
  mpd_bus_type bus_ff; // bus answer state

  // register select, reused by read and write
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // code decoder
  mpd_decode u_dec (
    .cfg_code(cfg_ff),
    .pin_level(mf_pin),
    .strobe(pin_strobe)
  );

  // bus handshake: one wait cycle, then ack
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus_ff <= MPD_IDLE;
    end else begin
      case (bus_ff)
        MPD_IDLE: if (avs_read || avs_write) bus_ff <= MPD_ACK;
        MPD_ACK: bus_ff <= MPD_DONE;
        MPD_DONE: bus_ff <= MPD_IDLE;
        default: bus_ff <= MPD_IDLE;
      endcase
    end
  end

  // waitrequest low only in ack cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_ff == MPD_IDLE && (avs_read || avs_write));
    end
  end

  // write accepted: the ack cycle of a held write
  always_comb begin
    wr_ack = (bus_ff == MPD_ACK) && avs_write;
  end

  // configuration byte, lane 0 only, updated at the ack edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      // no function attached after reset
      cfg_ff <= `MPD_CFG_RST;
    end else if (wr_ack && hit(avs_address, `MPD_CFG_OFS) && avs_byteenable[0]) begin
      // whole byte, direction bit included
      cfg_ff <= avs_writedata[7:0];
    end
  end

  // lane mask: lanes 0 and 1 whole, lane 2 only up to the top kept bit
  for (genvar g = 0; g < 3; g++) begin : g_lane
    if (g < 2) begin : g_full
      // full byte lane
      assign lane_mask[g*8 +: 8] = {8{avs_byteenable[g]}};
    end else begin : g_top
      // top lane, only the kept bits
      assign lane_mask[`MPD_S_W-1:16] = {(`MPD_S_W-16){avs_byteenable[g]}};
    end
  end

  // software control bits, merged lane by lane at the ack edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sw_ctrl_ff <= '0;
    end else if (wr_ack && hit(avs_address, `MPD_CTRL_OFS)) begin
      // bits of disabled lanes keep their value
      sw_ctrl_ff <= (sw_ctrl_ff & ~lane_mask) | (avs_writedata[`MPD_S_W-1:0] & lane_mask);
    end
  end

  // read data, prepared for the ack edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (bus_ff == MPD_IDLE && avs_read) begin
      if (hit(avs_address, `MPD_CFG_OFS))
        avs_readdata <= {24'h0, cfg_ff};
      else if (hit(avs_address, `MPD_STAT_OFS))
        avs_readdata <= {11'h0, nxt_strobe};
      else if (hit(avs_address, `MPD_CTRL_OFS))
        avs_readdata <= {11'h0, sw_ctrl_ff[`MPD_S_W-1:0]};
      else
        avs_readdata <= 32'h0;
    end
  end

  // pin acts exactly like the control bit: or with software
  always_comb begin
    nxt_strobe = sw_ctrl_ff[`MPD_S_W-1:0] | pin_strobe;
  end

  // mirror of the history clear bit, one edge behind the pin
  // tuning history reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      twh_reset_ff <= 1'b0;
    end else begin
      twh_reset_ff <= nxt_strobe[`MPD_S_TWH];
    end
  end

  // loop mode requests, levels held while the pin is high
  // holdover and free run
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      user_holdover_ff <= 1'b0;
      user_freerun_ff <= 1'b0;
    end else begin
      user_holdover_ff <= nxt_strobe[`MPD_S_HOLD];
      user_freerun_ff <= nxt_strobe[`MPD_S_FREE];
    end
  end

  // accumulated offset back to zero
  // phase offset reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reset_ff <= 1'b0;
    end else begin
      phase_reset_ff <= nxt_strobe[`MPD_S_PRST];
    end
  end

  // one increment up; the consumer counts its own steps
  // phase step up
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phase_inc_ff <= 1'b0;
    end else begin
      phase_inc_ff <= nxt_strobe[`MPD_S_PINC];
    end
  end

  // one increment down; the consumer counts its own steps
  // phase step down
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phase_dec_ff <= 1'b0;
    end else begin
      phase_dec_ff <= nxt_strobe[`MPD_S_PDEC];
    end
  end

  // distribution sync request
  // soft sync
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dist_sync_ff <= 1'b0;
    end else begin
      dist_sync_ff <= nxt_strobe[`MPD_S_SYNC];
    end
  end

  // reference a..d monitor overrides
  // monitor overrides
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mon_override_ff <= 4'h0;
    end else begin
      mon_override_ff <= nxt_strobe[`MPD_S_OVR +: 4];
    end
  end

  // reference a..d forced validation timeouts
  // validation timeouts
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      vto_force_ff <= 4'h0;
    end else begin
      vto_force_ff <= nxt_strobe[`MPD_S_VTO +: 4];
    end
  end

  // output channel enables zero to five
  // output enables
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      out_enable_ff <= 6'h0;
    end else begin
      out_enable_ff <= nxt_strobe[`MPD_S_OEN +: 6];
    end
  end
endmodule : mpd_top

// [sim/mpd_pin_src.sv]
// far-side board logic driving the multifunction pin
// assumes requests change just after a rising clock edge
`timescale 1ns/1ps
module mpd_pin_src (
  // clock and requested level
  input wire logic clock,
  input wire logic level_req,
  // pin toward the block
  output logic mf_pin
);
  logic lvl = 1'b0; // low before the first request
  // the pin moves one edge after a request
  always @(posedge clock) lvl <= level_req;
  assign mf_pin = lvl;
endmodule : mpd_pin_src

// [sim/mpd_top_props.sv]
// checker: strobes against shadowed config, control word and pin
// assumes it is bound into the top; control shadow follows byte lanes
`timescale 1ns/1ps
module mpd_props (
  input wire logic clock, sys_rst, avs_write, avs_waitrequest, mf_pin,
  input wire logic [3:0] avs_address, avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic twh_reset_ff, user_holdover_ff, user_freerun_ff, phase_reset_ff,
  input wire logic phase_inc_ff, phase_dec_ff, dist_sync_ff,
  input wire logic [3:0] mon_override_ff, vto_force_ff,
  input wire logic [5:0] out_enable_ff
);
  logic [7:0] cfg_ff; // shadow config
  logic [20:0] ctl_ff, rt, ev; // control, routed mask, expected
  // shadows follow accepted writes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ff <= 8'h00;
      ctl_ff <= '0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == 4'h0 && avs_byteenable[0]) cfg_ff <= avs_writedata[7:0];
      // control word, lane by lane; bits above 20 are not kept
      if (avs_address == 4'h8 && avs_byteenable[0]) ctl_ff[7:0] <= avs_writedata[7:0];
      if (avs_address == 4'h8 && avs_byteenable[1]) ctl_ff[15:8] <= avs_writedata[15:8];
      if (avs_address == 4'h8 && avs_byteenable[2]) ctl_ff[20:16] <= avs_writedata[20:16];
    end
  end
  // code to routed strobe; others route nothing
  always_comb begin
    rt = '0;
    case (cfg_ff)
      8'h05: rt = 21'h1;
      8'h10, 8'h11, 8'h12, 8'h13, 8'h14: rt = 21'h2 << (cfg_ff - 8'h10);
      8'h46: rt = 21'h1f8000;
      8'h47: rt = 21'h40;
      default: begin
        if (cfg_ff[7:2] == 6'h08) rt = 21'h80 << cfg_ff[1:0];
        if (cfg_ff[7:2] == 6'h0c) rt = 21'h800 << cfg_ff[1:0];
        if (cfg_ff[7:3] == 5'h08) rt = 21'h8000 << cfg_ff[2:0];
      end
    endcase
    ev = ctl_ff | (rt & {21{mf_pin}});
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence ack_s;
    avs_write && !avs_waitrequest;
  endsequence
  a_ack_then_wait: assert property (ack_s |=> avs_waitrequest) else $error("ack");
  // each strobe output equals control OR routed pin, one edge behind
  a_twh_mirror: assert property (twh_reset_ff == $past(ev[0])) else $error("twh");
  a_mode_mirror: assert property ({user_freerun_ff, user_holdover_ff} == $past(ev[2:1]))
    else $error("mode");
  a_phase_mirror: assert property ({phase_dec_ff, phase_inc_ff, phase_reset_ff}
    == $past(ev[5:3])) else $error("phase");
  a_sync_mirror: assert property (dist_sync_ff == $past(ev[6])) else $error("sync");
  a_ovr_mirror: assert property (mon_override_ff == $past(ev[10:7])) else $error("ovr");
  a_vto_mirror: assert property (vto_force_ff == $past(ev[14:11])) else $error("vto");
  a_oen_mirror: assert property (out_enable_ff == $past(ev[20:15])) else $error("oen");
endmodule : mpd_props

// [sim/mpd_top_tb.sv]
// bench: walks input codes, reserved codes, lanes and control bits
// assumes the checker and the pin source are compiled first
`timescale 1ns/1ps
module mpd_top_tb;
  logic clock = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, pin_req = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, mf_pin, twh_reset_ff, user_holdover_ff, user_freerun_ff;
  logic phase_reset_ff, phase_inc_ff, phase_dec_ff, dist_sync_ff;
  logic [3:0] mon_override_ff, vto_force_ff;
  logic [5:0] out_enable_ff;
  int n_fail = 0, num_checks = 0;
  wire logic [20:0] vec = {out_enable_ff, vto_force_ff, mon_override_ff, dist_sync_ff,
    phase_dec_ff, phase_inc_ff, phase_reset_ff, user_freerun_ff, user_holdover_ff, twh_reset_ff};
  // block under test, every pin by name
  mpd_top dut (
    .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mf_pin(mf_pin),
    .twh_reset_ff(twh_reset_ff), .user_holdover_ff(user_holdover_ff),
    .user_freerun_ff(user_freerun_ff), .phase_reset_ff(phase_reset_ff),
    .phase_inc_ff(phase_inc_ff), .phase_dec_ff(phase_dec_ff), .dist_sync_ff(dist_sync_ff),
    .mon_override_ff(mon_override_ff), .vto_force_ff(vto_force_ff),
    .out_enable_ff(out_enable_ff)
  );
  mpd_pin_src u_pin (.clock(clock), .level_req(pin_req), .mf_pin(mf_pin));
  initial forever #2 clock = ~clock;
  // one request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // set a code: silent with pin low, routed strobes with pin high
  task automatic walk(input logic [7:0] c, input logic [20:0] e);
    bus(1'b1, 4'h0, {24'h0, c}, 4'hf);
    repeat (3) @(posedge clock);
    chk(vec, 0);
    pin_req <= 1'b1;
    repeat (3) @(posedge clock);
    chk(vec, e);
    bus(1'b0, 4'h4, 0, 4'hf);
    chk(rd, e);
    pin_req <= 1'b0;
  endtask : walk
  // reset values: strobes, config and status all clear; unmapped ignored
  task automatic t_reset;
    chk(vec, 0);
    bus(1'b0, 4'h0, 0, 4'hf);
    chk(rd, 0);
    bus(1'b0, 4'h4, 0, 4'hf);
    chk(rd, 0);
    bus(1'b1, 4'hc, 32'h5, 4'hf);
    bus(1'b0, 4'hc, 0, 4'hf);
    chk(rd, 0);
  endtask : t_reset
  task automatic t_codes;
    // input codes and reserved codes; the last one stays for t_lane_ctrl
    logic [7:0] rsv [14] = '{8'h00, 8'h06, 8'h0f, 8'h15, 8'h24, 8'h3f, 8'h48, 8'h7f,
      8'h85, 8'h93, 8'ha0, 8'hb1, 8'hc6, 8'hc5};
    walk(8'h05, 21'h1);
    for (int i = 0; i < 5; i++) walk(8'(8'h10 + i), 21'h2 << i);
    for (int i = 0; i < 4; i++) walk(8'(8'h20 + i), 21'h80 << i);
    for (int i = 0; i < 4; i++) walk(8'(8'h30 + i), 21'h800 << i);
    for (int i = 0; i < 6; i++) walk(8'(8'h40 + i), 21'h8000 << i);
    walk(8'h46, 21'h1f8000);
    walk(8'h47, 21'h40);
    foreach (rsv[i]) walk(rsv[i], 0);
  endtask : t_codes
  // lane 0 off: config write ignored; control bit alone sets its strobe with pin low
  task automatic t_lane_ctrl;
    bus(1'b1, 4'h0, 32'h5, 4'he);
    pin_req <= 1'b1;
    repeat (3) @(posedge clock);
    chk(vec, 0);
    pin_req <= 1'b0;
    // config still holds the last reserved code
    bus(1'b0, 4'h0, 0, 4'hf);
    chk(rd, 32'hc5);
    bus(1'b1, 4'h8, 32'h1, 4'hf);
    repeat (3) @(posedge clock);
    chk(vec, 1);
    // lane 2 alone: only control bits 16 to 20 change
    bus(1'b1, 4'h8, 32'h001f_ffff, 4'h4);
    repeat (3) @(posedge clock);
    chk(vec, 21'h1f0001);
    bus(1'b0, 4'h8, 0, 4'hf);
    chk(rd, 32'h001f_0001);
  endtask : t_lane_ctrl
  task automatic wrap_up;
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset;
    t_codes;
    t_lane_ctrl;
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    wrap_up;
  end
endmodule : mpd_top_tb
bind mpd_top mpd_props u_props (
  .clock(clock), .sys_rst(sys_rst), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .mf_pin(mf_pin), .avs_address(avs_address),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .twh_reset_ff(twh_reset_ff), .user_holdover_ff(user_holdover_ff),
  .user_freerun_ff(user_freerun_ff), .phase_reset_ff(phase_reset_ff),
  .phase_inc_ff(phase_inc_ff), .phase_dec_ff(phase_dec_ff), .dist_sync_ff(dist_sync_ff),
  .mon_override_ff(mon_override_ff), .vto_force_ff(vto_force_ff),
  .out_enable_ff(out_enable_ff)
);
